// file: epe_engine.sv
// End-to-end protection engine: byte stream in, byte stream out, per block.
// Assumes each block arrives as its data bytes followed by its metadata bytes; in insert mode with 8 metadata bytes, as its data bytes alone.
`timescale 1ns/1ns
`default_nettype none
`include "epe_params.svh"
module epe_engine
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [7:0] out_data,
    input wire logic out_ready
);
    epe_pkg::epe_state_type st_r, st_nxt;
    logic [15:0] pos_r, pos_nxt, blk_r, blk_nxt, crc_r, crc_nxt, crc_out;
    logic [31:0] ref_r, ref_nxt;
    logic [63:0] rx_r, rx_nxt, rx_new, pi_word;
    logic [2:0] err_r, err_nxt, pk;
    logic done_r, done_nxt, ovld_r, ovld_nxt;
    logic [7:0] odat_r, odat_nxt, byte_in, obyte, gen;
    logic start;
    logic [9:0] cfg;
    logic [31:0] tags, ref0, sizes;
    logic [15:0] cnt, c_app, c_mask, c_blk, c_md, blk_len, mpos, pi_base;
    logic [2:0] c_chk;
    epe_pkg::epe_pi_kind_type c_type;
    logic c_dir, c_cmp, c_act, c_end;
    logic pi_on, md8, is_md, in_pi, covered, ins, strip, chk_on, cmp_mode;
    logic need_in, need_out, run, out_free, step, load, last, blk_end, fin;
    logic esc, e_g, e_a, e_r;
    logic [15:0] rg, ra;
    logic [31:0] rr;

    // ****************************************************************
    // Registers
    // ****************************************************************
    epe_apb_regs u_regs
    (
        .clk(clk),
        .rst_n(rst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .busy(run),
        .done(done_r),
        .err(err_r),
        .blk_done(blk_r),
        .start(start),
        .cfg(cfg),
        .tags(tags),
        .initial_ref_tag(ref0),
        .sizes(sizes),
        .blk_count(cnt)
    );

    assign c_dir = cfg[`EPE_CFG_DIR];
    assign c_cmp = cfg[`EPE_CFG_CMP];
    assign c_act = cfg[`EPE_CFG_ACT];
    assign c_chk = cfg[`EPE_CFG_CHK +: 3];
    assign c_type = epe_pkg::epe_pi_kind_type'(cfg[`EPE_CFG_TYPE +: 2]);
    assign c_end = cfg[`EPE_CFG_END];
    assign c_app = tags[15:0];
    assign c_mask = tags[31:16];
    assign c_blk = sizes[15:0];
    assign c_md = sizes[31:16];

    // ****************************************************************
    // Byte classification
    // ****************************************************************
    assign pi_on = (c_type != epe_pkg::epe_pi_none) && (c_md >= `EPE_PI_BYTES);
    assign md8 = c_md == `EPE_PI_BYTES;
    assign blk_len = 16'(c_blk + c_md);
    assign is_md = pos_r >= c_blk;
    assign mpos = 16'(pos_r - c_blk);
    assign pi_base = c_end ? 16'(c_md - `EPE_PI_BYTES) : 16'h0000;
    assign in_pi = pi_on && is_md && (mpos >= pi_base) && (mpos < 16'(pi_base + `EPE_PI_BYTES));
    assign pk = mpos[2:0] - pi_base[2:0];
    assign covered = !is_md || (c_end && (mpos < pi_base));
    assign ins = pi_on && !c_dir && c_act;
    assign strip = pi_on && c_dir && c_act && md8;
    assign chk_on = pi_on && !ins;
    assign cmp_mode = c_dir && c_cmp;
    assign need_in = !(ins && md8 && is_md);
    assign need_out = !(cmp_mode || (strip && is_md));

    // ****************************************************************
    // Stream handshake
    // ****************************************************************
    assign run = st_r == epe_pkg::epe_run;
    assign out_free = !ovld_r || out_ready;
    assign step = run && (!need_in || in_valid) && (!need_out || out_free);
    assign in_ready = run && need_in && (!need_out || out_free);
    assign load = step && need_out;
    assign byte_in = need_in ? in_data : 8'h00;
    assign pi_word = {crc_r, c_app, ref_r};
    assign gen = pi_word[{3'(3'd7 - pk), 3'b000} +: 8];
    assign obyte = (ins && in_pi) ? gen : byte_in;

    epe_crc16 u_crc
    (
        .crc_in(crc_r),
        .data_in(byte_in),
        .crc_out(crc_out)
    );

    // ****************************************************************
    // Block end checks
    // ****************************************************************
    assign last = pos_r == 16'(blk_len - 16'h0001);
    assign rx_new = (in_pi && chk_on) ? {rx_r[55:0], byte_in} : rx_r;
    assign rg = rx_new[63:48];
    assign ra = rx_new[47:32];
    assign rr = rx_new[31:0];
    assign esc = (c_type == epe_pkg::epe_pi_t3) ? ((ra == `EPE_APP_ESC) && (rr == `EPE_REF_ESC))
        : (ra == `EPE_APP_ESC);
    assign e_g = chk_on && !esc && c_chk[2] && (rg != crc_r);
    assign e_a = chk_on && !esc && c_chk[1] && (((ra ^ c_app) & c_mask) != 16'h0000);
    assign e_r = chk_on && !esc && c_chk[0] && (rr != ref_r);
    assign blk_end = step && last;
    assign fin = blk_end && (e_g || e_a || e_r || (16'(blk_r + 16'h0001) == cnt));

    // ****************************************************************
    // Command sequencing
    // ****************************************************************
    always_comb
    begin
        st_nxt = st_r;
        pos_nxt = pos_r;
        blk_nxt = blk_r;
        crc_nxt = crc_r;
        ref_nxt = ref_r;
        rx_nxt = rx_r;
        err_nxt = err_r;
        done_nxt = done_r;
        unique case (st_r)
            epe_pkg::epe_idle:
            begin
                if (start)
                begin
                    st_nxt = (cnt == 16'h0000) ? epe_pkg::epe_idle : epe_pkg::epe_run;
                    pos_nxt = 16'h0000;
                    blk_nxt = 16'h0000;
                    crc_nxt = `EPE_CRC_INIT;
                    ref_nxt = ref0;
                    rx_nxt = 64'h0;
                    err_nxt = 3'h0;
                    done_nxt = cnt == 16'h0000;
                end
            end
            epe_pkg::epe_run:
            begin
                if (step)
                begin
                    pos_nxt = 16'(pos_r + 16'h0001);
                    rx_nxt = rx_new;
                    if (covered)
                    begin
                        crc_nxt = crc_out;
                    end
                    if (last)
                    begin
                        pos_nxt = 16'h0000;
                        crc_nxt = `EPE_CRC_INIT;
                        ref_nxt = 32'(ref_r + 32'h1);
                        blk_nxt = 16'(blk_r + 16'h0001);
                    end
                    if (fin)
                    begin
                        st_nxt = epe_pkg::epe_idle;
                        done_nxt = 1'b1;
                        err_nxt = {e_g, e_a, e_r};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            st_r <= epe_pkg::epe_idle;
            pos_r <= 16'h0000;
            blk_r <= 16'h0000;
            crc_r <= `EPE_CRC_INIT;
            ref_r <= 32'h0;
            rx_r <= 64'h0;
            err_r <= 3'h0;
            done_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            pos_r <= pos_nxt;
            blk_r <= blk_nxt;
            crc_r <= crc_nxt;
            ref_r <= ref_nxt;
            rx_r <= rx_nxt;
            err_r <= err_nxt;
            done_r <= done_nxt;
        end
    end

    // ****************************************************************
    // Output register
    // ****************************************************************
    always_comb
    begin
        ovld_nxt = ovld_r;
        odat_nxt = odat_r;
        if (load)
        begin
            ovld_nxt = 1'b1;
            odat_nxt = obyte;
        end
        else if (out_ready)
        begin
            ovld_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ovld_r <= 1'b0;
            odat_r <= 8'h00;
        end
        else
        begin
            ovld_r <= ovld_nxt;
            odat_r <= odat_nxt;
        end
    end

    assign out_valid = ovld_r;
    assign out_data = odat_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    pass_unaltered_a: assert property (@(posedge clk) disable iff (!rst_n)
        (load && !pi_on) |=> (odat_r == $past(in_data)))
        else $error("unprotected byte altered");
    insert_no_input_a: assert property (@(posedge clk) disable iff (!rst_n)
        (run && ins && md8 && is_md) |-> !in_ready)
        else $error("insert mode took a metadata byte");
    strip_no_output_a: assert property (@(posedge clk) disable iff (!rst_n)
        (run && (cmp_mode || (strip && is_md))) |-> !load)
        else $error("stripped or compared byte sent");
    seed_ref_a: assert property (@(posedge clk) disable iff (!rst_n)
        (start && !run) |=> (ref_r == $past(ref0)))
        else $error("reference tag not seeded");
    ref_step_a: assert property (@(posedge clk) disable iff (!rst_n)
        blk_end |=> (ref_r == 32'($past(ref_r) + 32'h1)) && (crc_r == `EPE_CRC_INIT))
        else $error("reference tag or guard seed wrong at block end");
    guard_fail_a: assert property (@(posedge clk) disable iff (!rst_n)
        (blk_end && chk_on && !esc && c_chk[2] && (rg != crc_r)) |=> (err_r[2] && done_r && !run))
        else $error("guard mismatch not reported");
    escape_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
        (blk_end && esc) |=> (err_r == 3'h0))
        else $error("escaped block reported an error");
    app_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        (blk_end && (((ra ^ c_app) & c_mask) == 16'h0000)) |=> !err_r[1])
        else $error("masked tag bits caused a failure");
    gen_guard_a: assert property (@(posedge clk) disable iff (!rst_n)
        (load && ins && in_pi && (pk == 3'h0)) |=> (odat_r == 8'($past(crc_r) >> 8)))
        else $error("generated guard byte wrong");
endmodule : epe_engine
`default_nettype wire

// file: epe_params.svh
// Constants of the protection engine: register offsets, field positions,
// reset values and protection information constants.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef EPE_PARAMS_SVH
`define EPE_PARAMS_SVH
`define EPE_OFF_CTRL 12'h000
`define EPE_OFF_CFG 12'h004
`define EPE_OFF_TAG 12'h008
`define EPE_OFF_REF 12'h00c
`define EPE_OFF_SIZE 12'h010
`define EPE_OFF_COUNT 12'h014
`define EPE_OFF_STATUS 12'h018
`define EPE_CTRL_START 0
`define EPE_CFG_DIR 0
`define EPE_CFG_CMP 1
`define EPE_CFG_ACT 2
`define EPE_CFG_CHK 3
`define EPE_CFG_TYPE 6
`define EPE_CFG_END 8
`define EPE_CFG_SEP 9
`define EPE_CFG_RST 10'h000
`define EPE_ST_BUSY 0
`define EPE_ST_DONE 1
`define EPE_ST_ERR 2
`define EPE_ST_BLK 16
`define EPE_CRC_POLY 16'h8bb7
`define EPE_CRC_INIT 16'h0000
`define EPE_PI_BYTES 16'h0008
`define EPE_APP_ESC 16'hffff
`define EPE_REF_ESC 32'hffffffff
`endif

// file: epe_pkg.sv
// Types of the protection engine.
// Assumes epe_params.svh for all numeric constants.
`default_nettype none
package epe_pkg;
    typedef enum logic [0:0] {epe_idle, epe_run} epe_state_type;
    typedef enum logic [1:0] {epe_pi_none, epe_pi_t1, epe_pi_t2, epe_pi_t3} epe_pi_kind_type;
endpackage : epe_pkg
`default_nettype wire

// file: epe_crc16.sv
// One-byte step of the guard CRC-16.
// Assumes the caller registers the result and seeds it per block.
`timescale 1ns/1ns
`default_nettype none
`include "epe_params.svh"
module epe_crc16
(
    input wire logic [15:0] crc_in,
    input wire logic [7:0] data_in,
    output logic [15:0] crc_out
);
    logic [15:0] chain [0:8];

    assign chain[0] = crc_in;

    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1)
        begin : g_bit
            // Most significant data bit first, no reflection
            logic fb;
            assign fb = chain[i][15] ^ data_in[7 - i];
            assign chain[i + 1] = {chain[i][14:0], 1'b0} ^ (fb ? `EPE_CRC_POLY : 16'h0000);
        end
    endgenerate

    assign crc_out = chain[8];
endmodule : epe_crc16
`default_nettype wire

// file: epe_apb_regs.sv
// APB register file of the protection engine.
// Assumes a single clock domain; answers every access with no wait state.
`timescale 1ns/1ns
`default_nettype none
`include "epe_params.svh"
module epe_apb_regs
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic busy,
    input wire logic done,
    input wire logic [2:0] err,
    input wire logic [15:0] blk_done,
    output logic start,
    output logic [9:0] cfg,
    output logic [31:0] tags,
    output logic [31:0] initial_ref_tag,
    output logic [31:0] sizes,
    output logic [15:0] blk_count
);
    logic [9:0] cfg_r, cfg_nxt;
    logic [31:0] tag_r, tag_nxt, ref_r, ref_nxt, size_r, size_nxt, rd_r, rd_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic hit, wr;
    logic [31:0] rdv;

    // ****************************************************************
    // Decode
    // ****************************************************************
    always_comb
    begin
        hit = 1'b1;
        rdv = 32'h0000_0000;
        unique case (paddr)
            `EPE_OFF_CTRL: rdv = 32'h0000_0000;
            `EPE_OFF_CFG: rdv = {22'h000000, cfg_r};
            `EPE_OFF_TAG: rdv = tag_r;
            `EPE_OFF_REF: rdv = ref_r;
            `EPE_OFF_SIZE: rdv = size_r;
            `EPE_OFF_COUNT: rdv = {16'h0000, cnt_r};
            `EPE_OFF_STATUS: rdv = {blk_done, 11'h000, err, done, busy};
            default: hit = 1'b0;
        endcase
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign wr = psel & penable & pwrite & hit;
    // Command setup is frozen while a command runs
    assign start = wr & ~busy & (paddr == `EPE_OFF_CTRL) & pwdata[`EPE_CTRL_START];

    always_comb
    begin
        cfg_nxt = cfg_r;
        tag_nxt = tag_r;
        ref_nxt = ref_r;
        size_nxt = size_r;
        cnt_nxt = cnt_r;
        rd_nxt = rd_r;
        if (psel & ~penable & ~pwrite)
        begin
            rd_nxt = rdv;
        end
        if (wr & ~busy)
        begin
            if (paddr == `EPE_OFF_CFG)
            begin
                cfg_nxt = pwdata[9:0];
            end
            if (paddr == `EPE_OFF_TAG)
            begin
                tag_nxt = pwdata;
            end
            if (paddr == `EPE_OFF_REF)
            begin
                ref_nxt = pwdata;
            end
            if (paddr == `EPE_OFF_SIZE)
            begin
                size_nxt = pwdata;
            end
            if (paddr == `EPE_OFF_COUNT)
            begin
                cnt_nxt = pwdata[15:0];
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cfg_r <= `EPE_CFG_RST;
            tag_r <= 32'h0000_0000;
            ref_r <= 32'h0000_0000;
            size_r <= 32'h0000_0000;
            cnt_r <= 16'h0000;
            rd_r <= 32'h0000_0000;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            tag_r <= tag_nxt;
            ref_r <= ref_nxt;
            size_r <= size_nxt;
            cnt_r <= cnt_nxt;
            rd_r <= rd_nxt;
        end
    end

    assign prdata = rd_r;
    assign cfg = cfg_r;
    assign tags = tag_r;
    assign initial_ref_tag = ref_r;
    assign sizes = size_r;
    assign blk_count = cnt_r;
endmodule : epe_apb_regs
`default_nettype wire

// file: epe_partner.sv
// Far-side model: host buffers on writes, media on reads, as two byte streams.
// Assumes the bench loads src_q and reads got_q only between commands.
`timescale 1ns/1ns
`default_nettype none
module epe_partner
(
    input wire logic clk,
    input wire logic rst_n,
    output logic in_valid,
    output logic [7:0] in_data,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    output logic out_ready
);
    // ********************************
    // Source holds a byte until taken; sink may stall
    // ********************************
    logic [7:0] src_q[$];
    logic [7:0] got_q[$];
    bit slow;
    bit v;
    int cyc;
    initial
    begin
        in_valid = 1'b0;
        in_data = 8'h00;
        out_ready = 1'b0;
        slow = 1'b0;
        cyc = 0;
    end
    always @(posedge clk)
    begin
        cyc++;
        if (rst_n && out_valid && out_ready)
            got_q.push_back(out_data);
        if (rst_n && in_valid && in_ready)
            src_q.delete(0);
        if (!(rst_n && in_valid && !in_ready && src_q.size() > 0))
        begin
            v = rst_n && src_q.size() > 0 && !(slow && cyc[0]);
            in_valid <= v;
            // Idle line toggles so a stale byte is never mistaken for data
            in_data <= v ? src_q[0] : ~in_data;
        end
        out_ready <= rst_n && !(slow && cyc[1]);
    end
endmodule : epe_partner
`default_nettype wire

// file: testbench.sv
// Self-checking bench of the protection engine: APB set-up, byte streams via the partner.
// Assumes epe_params.svh register map and a 4-byte block data size.
`timescale 1ns/1ns
`default_nettype none
`include "epe_params.svh"
`define CHK(g, e) \
    begin \
        total_checks++; \
        if ((g) !== (e)) \
        begin \
            errors++; \
            $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); \
        end \
    end
module testbench;
    // ********************************
    // Clock, reset, instances
    // ********************************
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic in_valid, in_ready, out_valid, out_ready;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [7:0] in_data, out_data;
    logic rerr;
    logic [7:0] b[$], d[$], src[$], ex[$];
    int errors = 0;
    int total_checks = 0;
    epe_engine epe_engine_i (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .out_valid(out_valid),
        .out_data(out_data), .out_ready(out_ready));
    epe_partner epe_partner_i (.clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_data(in_data),
        .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic conclude;
        if (errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= dt;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] x);
        for (int i = 7; i >= 0; i--)
            c = (c[15] ^ x[i]) ? ((c << 1) ^ `EPE_CRC_POLY) : (c << 1);
        return c;
    endfunction : crc_step
    function automatic logic [9:0] cf(logic dir, logic cmp, logic act, logic [2:0] chk, logic [1:0] ty,
        logic pe);
        return {1'b0, pe, ty, chk, act, cmp, dir};
    endfunction : cf
    // Builds one block into b (data, then metadata with protection at its end if pe, else at its start) and its data alone into d
    task automatic mkblk(input int md, input bit pe, input logic [15:0] app, input logic [31:0] rt,
        input logic [15:0] gx);
        logic [15:0] c;
        logic [7:0] xm[$];
        logic [7:0] pi[$];
        c = `EPE_CRC_INIT;
        d = {};
        for (int i = 0; i < 4; i++)
            d.push_back(8'h31 + rt[7:0] + 8'(i));
        for (int i = 0; i < md - 8; i++)
            xm.push_back(8'hc0 + 8'(i));
        foreach (d[i]) c = crc_step(c, d[i]);
        if (pe)
            foreach (xm[i]) c = crc_step(c, xm[i]);
        c ^= gx;
        pi = {c[15:8], c[7:0], app[15:8], app[7:0], rt[31:24], rt[23:16], rt[15:8], rt[7:0]};
        if (pe)
            b = {d, xm, pi};
        else
            b = {d, pi, xm};
    endtask : mkblk
    task automatic run(input logic [9:0] c, input logic [31:0] tg, input logic [31:0] rt,
        input logic [15:0] md, input logic [15:0] cnt, input logic [2:0] ee);
        apb(1'b1, `EPE_OFF_CFG, {22'h0, c});
        apb(1'b1, `EPE_OFF_TAG, tg);
        apb(1'b1, `EPE_OFF_REF, rt);
        apb(1'b1, `EPE_OFF_SIZE, {md, 16'h0004});
        apb(1'b1, `EPE_OFF_COUNT, {16'h0, cnt});
        epe_partner_i.got_q = {};
        epe_partner_i.src_q = src;
        apb(1'b1, `EPE_OFF_CTRL, 32'h1);
        rdat = 32'h0;
        for (int i = 0; i < 400 && rdat[`EPE_ST_DONE] !== 1'b1; i++)
            apb(1'b0, `EPE_OFF_STATUS, 32'h0);
        `CHK(rdat[`EPE_ST_BUSY], 1'b0)
        `CHK(rdat[4:2], ee)
        `CHK(rdat[`EPE_ST_DONE], 1'b1)
        for (int i = 0; i < 20 && out_valid === 1'b1; i++)
            @(posedge clk);
        `CHK(out_valid, 1'b0)
        `CHK(epe_partner_i.got_q.size(), ex.size())
        foreach (ex[i]) `CHK(epe_partner_i.got_q[i], ex[i])
        epe_partner_i.src_q = {};
        src = {};
        ex = {};
    endtask : run
    // ********************************
    // Scenarios
    // ********************************
    task automatic t_regs;
        apb(1'b0, `EPE_OFF_CFG, 32'h0);
        `CHK(rdat, 32'h0)
        apb(1'b1, `EPE_OFF_TAG, 32'h1234abcd);
        apb(1'b0, `EPE_OFF_TAG, 32'h0);
        `CHK(rdat, 32'h1234abcd)
        apb(1'b0, 12'h01c, 32'h0);
        `CHK(rerr, 1'b1)
        `CHK(rdat, 32'h0)
    endtask : t_regs
    task automatic t_write;
        epe_partner_i.slow = 1'b1;
        for (int k = 0; k < 3; k++)
        begin
            mkblk(8, 0, 16'h0042, 32'h100 + k, 16'h0);
            src = {src, b};
            ex = {ex, b};
        end
        run(cf(0, 0, 0, 7, 1, 0), 32'hffff0042, 32'h100, 16'd8, 16'd3, 3'b000);
        epe_partner_i.slow = 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            mkblk(8, 0, 16'h0a0b, 32'h200 + k, 16'h0);
            src = {src, d};
            ex = {ex, b};
        end
        run(cf(0, 0, 1, 0, 2, 0), 32'h00000a0b, 32'h200, 16'd8, 16'd2, 3'b000);
        mkblk(16, 1, 16'h0a0b, 32'h300, 16'h0);
        ex = b;
        mkblk(16, 1, 16'h5555, 32'h0, 16'h1);
        src = b;
        run(cf(0, 0, 1, 0, 1, 1), 32'h00000a0b, 32'h300, 16'd16, 16'd1, 3'b000);
        mkblk(8, 0, 16'h0001, 32'h9, 16'h00ff);
        src = b;
        ex = b;
        run(cf(0, 0, 1, 7, 0, 0), 32'h0, 32'h0, 16'd8, 16'd1, 3'b000);
    endtask : t_write
    task automatic t_read;
        mkblk(8, 0, 16'h0007, 32'h400, 16'h0);
        src = b;
        ex = d;
        run(cf(1, 0, 1, 7, 1, 0), 32'hffff0007, 32'h400, 16'd8, 16'd1, 3'b000);
        src = b;
        ex = b;
        run(cf(1, 0, 0, 7, 1, 0), 32'hffff0007, 32'h400, 16'd8, 16'd1, 3'b000);
        mkblk(16, 0, 16'h0007, 32'h400, 16'h0);
        src = b;
        ex = b;
        run(cf(1, 0, 1, 7, 3, 0), 32'hffff0007, 32'h400, 16'd16, 16'd1, 3'b000);
    endtask : t_read
    task automatic t_checks;
        logic [1:0] ty[7] = '{1, 1, 1, 2, 1, 3, 3};
        logic [15:0] ap[7] = '{16'h42, 16'h43, 16'h43, 16'h42, 16'hffff, 16'hffff, 16'hffff};
        logic [31:0] rp[7] = '{32'h500, 32'h500, 32'h500, 32'h501, 32'h501, 32'h501, 32'hffffffff};
        logic [15:0] mk[7] = '{16'hffff, 16'hffff, 16'hfffe, 16'hffff, 16'hffff, 16'hffff, 16'hffff};
        logic [2:0] ee[7] = '{3'b100, 3'b010, 3'b000, 3'b001, 3'b000, 3'b111, 3'b000};
        for (int k = 0; k < 7; k++)
        begin
            mkblk(8, 0, ap[k], rp[k], {15'h0, ee[k][2]});
            src = b;
            run(cf(1, 1, 0, 7, ty[k], 0), {mk[k], 16'h0042}, 32'h500, 16'd8, 16'd1, ee[k]);
        end
        mkblk(8, 0, 16'h42, 32'h600, 16'h0);
        src = {b, b};
        run(cf(1, 1, 0, 1, 1, 0), 32'hffff0042, 32'h600, 16'd8, 16'd2, 3'b001);
        `CHK(rdat[31:16], 16'h0002)
    endtask : t_checks
    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_write();
        t_read();
        t_checks();
        conclude();
    end
    initial
    begin
        #500000;
        errors++;
        conclude();
    end
endmodule : testbench
`default_nettype wire
